// ### common/tsi_irq_pkg.sv
// constants for the time-slot interchanger interrupt aggregator
// Overview of operation
// - with bit 0 of the global enable register cleared the interrupt output stays low whatever the mask holds.
// - with the global enable bit at 1 the interrupt follows the status bits gated by their mask bits.
// - bits 7 to 1 of the global enable register always read as zero.
// - status bit 6 is set when the frame sync input is missing or arrives misaligned.
// - status bit 5 mirrors the pattern checker, 0 before the pattern is located and 1 after.
// - the checker declares detection only after 32 consecutive error-free checked slots, accumulated across frames.
// - once the pattern has been detected, every checker error sets status bit 3.
// - the end of the memory self-test sets status bit 1.
// - completion of a requested bit-error insertion sets status bit 0.
// - the status register is read-only and a read clears the sticky bits 6, 3, 1, 0 it returned until their next event.
// - status bits update whatever the mask holds, except the frame error flag, which a set mask bit blocks.
// - in the status register bit 4 may read as either value and bits 7 and 2 read as zero.
// - mask bits sit at status positions 6, 5, 3, 1, 0, reset to 1, and a 1 always masks.
package tsi_irq_pkg;
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          REG_W        = 8;
    // printed offsets are word indexes; byte address is four times the index
    localparam logic [7:0]  GATE_IDX     = 8'h06;
    localparam logic [7:0]  STAT_IDX     = 8'h07;
    localparam logic [7:0]  MASK_IDX     = 8'h08;
    localparam logic [7:0]  CLR_IDX      = 8'h0B;
    localparam logic [7:0]  GATE_ADDR    = GATE_IDX << 2;
    localparam logic [7:0]  STAT_ADDR    = STAT_IDX << 2;
    localparam logic [7:0]  MASK_ADDR    = MASK_IDX << 2;
    localparam logic [7:0]  CLR_ADDR     = CLR_IDX << 2;
    // field positions
    localparam int          GATE_BIT     = 0;
    localparam int          FS_BIT       = 6;
    localparam int          FOUND_BIT    = 5;
    localparam int          PERR_BIT     = 3;
    localparam int          SELFTEST_BIT = 1;
    localparam int          INJECT_BIT   = 0;
    // reset values and layouts
    localparam logic [7:0]  GATE_RST     = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'h7F;
    localparam logic [7:0]  MASK_USED    = 8'h6B;
    localparam logic [7:0]  MASK_ONES    = 8'h14;
    localparam logic [7:0]  STICKY_USED  = 8'h4B;
    localparam logic [7:0]  STAT_RST     = 8'h00;
    // timing
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          FRAME_PERIOD_NS = 125000;
    localparam int          FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          LOCK_SLOTS      = 32;
endpackage

// ### design/pattern_lock.sv
// test-pattern checker lock tracker
`timescale 1ns/100ps
module pattern_lock #(
    parameter int LOCK_SLOTS = tsi_irq_pkg::LOCK_SLOTS
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // checker slot results
    input  wire logic checker_enable,
    input  wire logic slot_checked,
    input  wire logic slot_error,
    // lock state
    output logic      pattern_found_r
);
    import tsi_irq_pkg::*;

    localparam int CW = $clog2(LOCK_SLOTS + 1);
    localparam logic [CW-1:0] LAST = CW'(LOCK_SLOTS - 1);

    logic [CW-1:0] good_cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // the count survives frame boundaries, so few slots per frame still lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            good_cnt_r <= '0;
        end else if (!checker_enable || pattern_found_r) begin
            good_cnt_r <= '0;
        end else if (slot_checked && slot_error) begin
            good_cnt_r <= '0;
        end else if (slot_checked) begin
            good_cnt_r <= good_cnt_r + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_found_r <= 1'b0;
        end else if (!checker_enable) begin
            pattern_found_r <= 1'b0;
        end else if (slot_checked && !slot_error && good_cnt_r == LAST) begin
            pattern_found_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_lock_after_run;
        $rose(pattern_found_r) |-> $past(good_cnt_r) == LAST && $past(slot_checked) && !$past(slot_error);
    endproperty
    a_lock_after_run: assert property (p_lock_after_run) else $error("lock without full error-free run");

    property p_error_restarts;
        checker_enable && !pattern_found_r && slot_checked && slot_error |=> good_cnt_r == '0 && !pattern_found_r;
    endproperty
    a_error_restarts: assert property (p_error_restarts) else $error("slot error did not restart run");
endmodule

// ### design/tsi_interrupt_aggregator.sv
// interrupt gate, status and mask registers behind an apb slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module tsi_interrupt_aggregator #(
    parameter int FRAME_CYCLES = tsi_irq_pkg::FRAME_CYCLES,
    parameter int LOCK_SLOTS   = tsi_irq_pkg::LOCK_SLOTS
) (
    // clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // apb slave
    input  wire logic [tsi_irq_pkg::ADDR_W-1:0] paddr,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [tsi_irq_pkg::DATA_W-1:0] pwdata,
    output logic      [tsi_irq_pkg::DATA_W-1:0] prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // frame timing pin
    input  wire logic                            frame_sync_in,
    // pattern checker
    input  wire logic                            checker_enable,
    input  wire logic                            slot_checked,
    input  wire logic                            slot_error,
    // self-test and error insertion
    input  wire logic                            selftest_done,
    input  wire logic                            injection_done,
    // interrupt
    output logic                                 irq_out
);
    import tsi_irq_pkg::*;

    localparam int FW = $clog2(FRAME_CYCLES + 1);
    localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);

    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] r);
        addr_is = (a == r);
    endfunction

    logic [REG_W-1:0]  global_irq_enable_r;
    logic [REG_W-1:0]  irq_event_status_r;
    logic [REG_W-1:0]  irq_event_status_nxt;
    logic [REG_W-1:0]  irq_event_mask_r;
    logic [REG_W-1:0]  stat_set;
    logic [REG_W-1:0]  stat_clr;
    logic [REG_W-1:0]  stat_view;
    logic [REG_W-1:0]  rd_val;
    logic [DATA_W-1:0] prdata_r;
    logic              setup_rd;
    logic              acc_rd;
    logic              acc_wr;
    logic              addr_hit;
    logic              sync_s1_r;
    logic              sync_s2_r;
    logic              sync_d_r;
    logic              sync_edge;
    logic              armed_r;
    logic [FW-1:0]     frame_cnt_r;
    logic              fs_event;
    logic              pattern_found_flag;
    logic              err_event;
    logic              selftest_d_r;
    logic              irq_r;
    logic              global_irq_gate;
    logic              frame_timing_error_mask;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; every access completes in its first access cycle
    assign addr_hit = addr_is(paddr, GATE_ADDR) || addr_is(paddr, STAT_ADDR)
                   || addr_is(paddr, MASK_ADDR) || addr_is(paddr, CLR_ADDR);
    assign setup_rd = psel && !penable && !pwrite;
    assign acc_rd   = psel && penable && !pwrite && addr_hit;
    assign acc_wr   = psel && penable && pwrite && addr_hit;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_hit;
    assign prdata   = prdata_r;

    assign global_irq_gate         = global_irq_enable_r[GATE_BIT];
    assign frame_timing_error_mask = irq_event_mask_r[FS_BIT];

    ////////////////////////////////////////////////////////////////////////
    // read data is captured in the setup cycle so a read clears exactly
    // the sticky bits that were returned; later events are kept
    always_comb begin
        rd_val = '0;
        if (addr_is(paddr, GATE_ADDR)) begin
            rd_val = {7'h00, global_irq_gate};
        end else if (addr_is(paddr, STAT_ADDR)) begin
            rd_val = stat_view;
        end else if (addr_is(paddr, MASK_ADDR)) begin
            rd_val = (irq_event_mask_r & MASK_USED) | MASK_ONES;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup_rd) begin
            prdata_r <= {24'h000000, rd_val};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // global gate register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable_r <= GATE_RST;
        end else if (acc_wr && addr_is(paddr, GATE_ADDR)) begin
            global_irq_enable_r <= {7'h00, pwdata[GATE_BIT]};
        end
    end

    // mask register; unused bits 4 and 2 are held at one and bit 7 at zero whatever is written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_event_mask_r <= MASK_RST;
        end else if (acc_wr && addr_is(paddr, MASK_ADDR)) begin
            irq_event_mask_r <= (pwdata[REG_W-1:0] & MASK_USED) | MASK_ONES;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame sync pin: two flops, then an edge from the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_s1_r <= 1'b0;
            sync_s2_r <= 1'b0;
            sync_d_r  <= 1'b0;
        end else begin
            sync_s1_r <= frame_sync_in;
            sync_s2_r <= sync_s1_r;
            sync_d_r  <= sync_s2_r;
        end
    end

    assign sync_edge = sync_s2_r && !sync_d_r;

    // a sync off the expected cycle is misaligned; none at the expected
    // cycle is missing, after which the timer waits for the next sync
    assign fs_event = armed_r && (sync_edge ? (frame_cnt_r != FRAME_LAST)
                                            : (frame_cnt_r == FRAME_LAST));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r     <= 1'b0;
            frame_cnt_r <= '0;
        end else if (sync_edge) begin
            armed_r     <= 1'b1;
            frame_cnt_r <= '0;
        end else if (armed_r && frame_cnt_r == FRAME_LAST) begin
            armed_r     <= 1'b0;
            frame_cnt_r <= '0;
        end else if (armed_r) begin
            frame_cnt_r <= frame_cnt_r + FW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pattern checker lock
    pattern_lock #(
        .LOCK_SLOTS (LOCK_SLOTS)
    ) pattern_lock_inst (
        .pclk            (pclk),
        .presetn         (presetn),
        .checker_enable  (checker_enable),
        .slot_checked    (slot_checked),
        .slot_error      (slot_error),
        .pattern_found_r (pattern_found_flag)
    );

    assign err_event = pattern_found_flag && slot_checked && slot_error;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            selftest_d_r <= 1'b0;
        end else begin
            selftest_d_r <= selftest_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status: set wins over the read clear and over the clear register
    always_comb begin
        stat_set          = '0;
        stat_set[FS_BIT]       = fs_event && !frame_timing_error_mask;
        stat_set[PERR_BIT]     = err_event;
        stat_set[SELFTEST_BIT] = selftest_done && !selftest_d_r;
        stat_set[INJECT_BIT]   = injection_done;
    end

    always_comb begin
        stat_clr = '0;
        if (acc_rd && addr_is(paddr, STAT_ADDR)) begin
            stat_clr = prdata_r[REG_W-1:0] & STICKY_USED;
        end else if (acc_wr && addr_is(paddr, CLR_ADDR)) begin
            stat_clr = pwdata[REG_W-1:0] & STICKY_USED;
        end
    end

    assign irq_event_status_nxt = ((irq_event_status_r & ~stat_clr) | stat_set) & STICKY_USED;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_event_status_r <= STAT_RST;
        end else begin
            irq_event_status_r <= irq_event_status_nxt;
        end
    end

    // bit 5 is live lock state, not sticky; bits 7, 4 and 2 read zero
    always_comb begin
        stat_view          = irq_event_status_r;
        stat_view[FOUND_BIT] = pattern_found_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // level interrupt, registered so the pin never glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= global_irq_gate && |(stat_view & ~irq_event_mask_r & MASK_USED);
        end
    end

    assign irq_out = irq_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_gate_off;
        !global_irq_gate |=> !irq_out;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("interrupt with gate cleared");

    property p_irq_on;
        global_irq_gate && |(stat_view & ~irq_event_mask_r & MASK_USED) |=> irq_out;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("unmasked status did not raise interrupt");

    property p_irq_drop;
        global_irq_gate && (stat_view & ~irq_event_mask_r & MASK_USED) == '0 |=> !irq_out;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("interrupt with nothing pending");

    property p_gate_rsv;
        setup_rd && addr_is(paddr, GATE_ADDR) |=> prdata[7:1] == 7'h00;
    endproperty
    a_gate_rsv: assert property (p_gate_rsv) else $error("gate reserved bits not zero");

    property p_fs_set;
        fs_event && !frame_timing_error_mask |=> irq_event_status_r[FS_BIT];
    endproperty
    a_fs_set: assert property (p_fs_set) else $error("frame error not flagged");

    property p_fs_masked;
        frame_timing_error_mask && !irq_event_status_r[FS_BIT] |=> !irq_event_status_r[FS_BIT];
    endproperty
    a_fs_masked: assert property (p_fs_masked) else $error("masked frame error was flagged");

    property p_found_read;
        setup_rd && addr_is(paddr, STAT_ADDR) |=> prdata[FOUND_BIT] == $past(pattern_found_flag);
    endproperty
    a_found_read: assert property (p_found_read) else $error("bit 5 does not mirror checker");

    property p_perr_set;
        pattern_found_flag && slot_checked && slot_error |=> irq_event_status_r[PERR_BIT];
    endproperty
    a_perr_set: assert property (p_perr_set) else $error("pattern error not flagged");

    property p_selftest_set;
        $rose(selftest_done) |=> irq_event_status_r[SELFTEST_BIT];
    endproperty
    a_selftest_set: assert property (p_selftest_set) else $error("self-test end not flagged");

    property p_inject_set;
        injection_done |=> irq_event_status_r[INJECT_BIT];
    endproperty
    a_inject_set: assert property (p_inject_set) else $error("insertion end not flagged");

    property p_read_clears;
        acc_rd && addr_is(paddr, STAT_ADDR) && stat_set == '0
            |=> (irq_event_status_r & $past(prdata_r[7:0]) & STICKY_USED) == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear returned bits");

    property p_stat_rsv;
        setup_rd && addr_is(paddr, STAT_ADDR) |=> !prdata[7] && !prdata[2];
    endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status reserved bits not zero");

    property p_mask_ones;
        setup_rd && addr_is(paddr, MASK_ADDR) |=> prdata[4] && prdata[2] && !prdata[7];
    endproperty
    a_mask_ones: assert property (p_mask_ones) else $error("mask reserved bits wrong");

    property p_found_drop;
        !checker_enable |=> !pattern_found_flag;
    endproperty
    a_found_drop: assert property (p_found_drop) else $error("lock kept with checker stopped");

    property p_perr_before_lock;
        !pattern_found_flag && !irq_event_status_r[PERR_BIT] |=> !irq_event_status_r[PERR_BIT];
    endproperty
    a_perr_before_lock: assert property (p_perr_before_lock) else $error("error flagged before lock");

    property p_inject_stays_clear;
        !irq_event_status_r[INJECT_BIT] && !injection_done |=> !irq_event_status_r[INJECT_BIT];
    endproperty
    a_inject_stays_clear: assert property (p_inject_stays_clear) else $error("cleared bit set alone");

    property p_stat_unused;
        (irq_event_status_r & ~STICKY_USED) == '0;
    endproperty
    a_stat_unused: assert property (p_stat_unused) else $error("unused status bit set");

    property p_mask_ones_hold;
        (irq_event_mask_r & MASK_ONES) == MASK_ONES;
    endproperty
    a_mask_ones_hold: assert property (p_mask_ones_hold) else $error("mask reserved bits lost");

    property p_gate_write;
        psel && penable && pwrite && addr_is(paddr, GATE_ADDR) |=> global_irq_gate == $past(pwdata[GATE_BIT]);
    endproperty
    a_gate_write: assert property (p_gate_write) else $error("gate write not taken");

    // clear register write; a set in the same cycle may keep a bit
    property p_clr_write;
        psel && penable && pwrite && addr_is(paddr, CLR_ADDR) && stat_set == '0
            |=> (irq_event_status_r & $past(pwdata[REG_W-1:0]) & STICKY_USED) == '0;
    endproperty
    a_clr_write: assert property (p_clr_write) else $error("clear write did not clear");

    property p_unmapped_nowrite;
        psel && penable && !addr_hit |=> $stable(global_irq_enable_r) && $stable(irq_event_mask_r);
    endproperty
    a_unmapped_nowrite: assert property (p_unmapped_nowrite) else $error("unmapped access changed a register");

    property p_slverr_idle;
        !(psel && penable) |-> !pslverr;
    endproperty
    a_slverr_idle: assert property (p_slverr_idle) else $error("error outside access cycle");
endmodule

// ### dv/sync_source.sv
// frame sync pulse source standing in for the highway timing logic
`timescale 1ns/100ps
module sync_source (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control from the bench
    input  wire logic run,
    input  wire integer period,
    // frame sync pin
    output logic      frame_sync_in
);
    int cnt_r;

    // one-cycle pulse every period cycles; a shortened period yields a misaligned pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r         <= 0;
            frame_sync_in <= 1'b0;
        end else if (!run) begin
            cnt_r         <= 0;
            frame_sync_in <= 1'b0;
        end else if (cnt_r >= period - 1) begin
            cnt_r         <= 0;
            frame_sync_in <= 1'b1;
        end else begin
            cnt_r         <= cnt_r + 1;
            frame_sync_in <= 1'b0;
        end
    end
endmodule

// ### dv/tsi_interrupt_aggregator_tb_top.sv
// self-checking bench for the interrupt aggregator
`timescale 1ns/100ps
module tsi_interrupt_aggregator_tb_top;
    import tsi_irq_pkg::*;
    localparam int FC = 20;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, frame_sync_in, irq_out;
    logic        checker_enable = 1'b0, slot_checked = 1'b0, slot_error = 1'b0;
    logic        selftest_done = 1'b0, injection_done = 1'b0, run = 1'b0;
    int          period = FC;
    int          fails = 0, n_compared = 0;

    always #25 pclk = ~pclk;

    tsi_interrupt_aggregator #(.FRAME_CYCLES(FC), .LOCK_SLOTS(4)) tsi_interrupt_aggregator_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_sync_in(frame_sync_in), .checker_enable(checker_enable), .slot_checked(slot_checked),
        .slot_error(slot_error), .selftest_done(selftest_done), .injection_done(injection_done),
        .irq_out(irq_out));

    sync_source sync_source_inst (.pclk(pclk), .presetn(presetn), .run(run), .period(period),
        .frame_sync_in(frame_sync_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // setup then access; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, a, {24'h0, d}, rd, err);
        check({31'h0, err}, 32'h0, "write error");
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        logic [31:0] rd;
        logic        err;
        xfer(1'b0, a, 32'h0, rd, err);
        check(rd & {24'h0, m}, {24'h0, exp & m}, "read value");
    endtask

    task automatic inject();
        injection_done <= 1'b1;
        @(posedge pclk);
        injection_done <= 1'b0;
    endtask

    task automatic slot(input logic e);
        slot_checked <= 1'b1;
        slot_error <= e;
        @(posedge pclk);
        slot_checked <= 1'b0;
        slot_error <= 1'b0;
        @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] rd;
        logic        err;
        reg_rd(GATE_ADDR, 8'h00, 8'hFF);
        reg_rd(MASK_ADDR, 8'h7F, 8'hFF);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        reg_wr(GATE_ADDR, 8'hFF);
        reg_rd(GATE_ADDR, 8'h01, 8'hFF);
        reg_wr(GATE_ADDR, 8'h00);
        reg_wr(MASK_ADDR, 8'h14);
        reg_rd(MASK_ADDR, 8'h14, 8'hFF);
        reg_wr(MASK_ADDR, 8'h7F);
        reg_wr(STAT_ADDR, 8'h4B);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        xfer(1'b0, 8'h3C, 32'h0, rd, err);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        $display("test regs done");
    endtask

    task automatic t_events();
        reg_wr(GATE_ADDR, 8'h01);
        inject();
        selftest_done <= 1'b1;
        cyc(3);
        check({31'h0, irq_out}, 32'h0, "irq while masked");
        reg_rd(STAT_ADDR, 8'h03, 8'hFF);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        selftest_done <= 1'b0;
        reg_wr(GATE_ADDR, 8'h00);
        $display("test events done");
    endtask

    task automatic t_irq();
        reg_wr(MASK_ADDR, 8'h7E);
        inject();
        cyc(3);
        check({31'h0, irq_out}, 32'h0, "irq with gate off");
        reg_wr(GATE_ADDR, 8'h01);
        cyc(2);
        check({31'h0, irq_out}, 32'h1, "irq with gate on");
        cyc(5);
        check({31'h0, irq_out}, 32'h1, "irq level held");
        reg_rd(STAT_ADDR, 8'h01, 8'hFF);
        cyc(2);
        check({31'h0, irq_out}, 32'h0, "irq after read clear");
        inject();
        cyc(3);
        check({31'h0, irq_out}, 32'h1, "irq second event");
        reg_wr(CLR_ADDR, 8'h01);
        cyc(2);
        check({31'h0, irq_out}, 32'h0, "irq after clear write");
        reg_rd(CLR_ADDR, 8'h00, 8'hFF);
        reg_wr(MASK_ADDR, 8'h7F);
        inject();
        cyc(3);
        check({31'h0, irq_out}, 32'h0, "irq masked again");
        reg_rd(STAT_ADDR, 8'h01, 8'hFF);
        $display("test irq done");
    endtask

    task automatic t_lock();
        checker_enable <= 1'b1;
        repeat (3) slot(1'b0);
        slot(1'b1);
        repeat (3) slot(1'b0);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        slot(1'b0);
        cyc(1);
        reg_rd(STAT_ADDR, 8'h20, 8'hFF);
        slot(1'b1);
        cyc(1);
        reg_rd(STAT_ADDR, 8'h28, 8'hFF);
        reg_rd(STAT_ADDR, 8'h20, 8'hFF);
        checker_enable <= 1'b0;
        cyc(2);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        $display("test lock done");
    endtask

    task automatic t_frame();
        // masked: misaligned and missing pulses leave the flag clear
        period <= 13;
        run <= 1'b1;
        cyc(60);
        run <= 1'b0;
        cyc(3 * FC);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        reg_wr(MASK_ADDR, 8'h3F);
        period <= FC;
        run <= 1'b1;
        cyc(5 * FC);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        period <= 13;
        cyc(40);
        reg_rd(STAT_ADDR, 8'h40, 8'hFF);
        period <= FC;
        cyc(4 * FC);
        reg_rd(STAT_ADDR, 8'h00, 8'h00);
        reg_rd(STAT_ADDR, 8'h00, 8'hFF);
        run <= 1'b0;
        cyc(3 * FC);
        reg_rd(STAT_ADDR, 8'h40, 8'hFF);
        reg_wr(MASK_ADDR, 8'h7F);
        $display("test frame done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        fails++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({31'h0, irq_out}, 32'h0, "irq after reset");
        t_regs();
        t_events();
        t_irq();
        t_lock();
        t_frame();
        wrap_up();
    end
endmodule
